// ===== include/fmc_pkg.sv
/*
  Constants shared by the fan monitor configuration/status register block.
  Assumes an 8-bit register byte port fed by an SMBus slave engine.
*/
package fmc_pkg;
  localparam logic [7:0] FMC_STATUS_ONE_ADDR = 8'h02;
  localparam logic [7:0] FMC_CONFIG_FOUR_ADDR = 8'h04;
  localparam logic [7:0] FMC_STATUS_ONE_RESET = 8'h00;
  localparam logic [7:0] FMC_CONFIG_FOUR_RESET = 8'h08;
  // fixed low nibble of the config register: bit 3 one, bits 2..0 zero
  localparam logic [3:0] FMC_CONFIG_FIXED_BITS = 4'h8;
  localparam int FMC_CFG_MODE_BIT = 7;
  localparam int FMC_CFG_PULSES_BIT = 6;
  localparam int FMC_CFG_FAST_BIT = 5;
  localparam int FMC_CFG_OUTEN_BIT = 4;
  localparam int FMC_ST_LOCAL_LOW_BIT = 7;
  localparam int FMC_ST_LOCAL_HIGH_BIT = 6;
  localparam int FMC_ST_SENSOR_FAIL_BIT = 5;
  localparam int FMC_ST_REMOTE_CRIT_BIT = 4;
  // remote temperature value forced on a sensor fault (-128 C)
  localparam logic [7:0] FMC_FAULT_TEMP = 8'h80;
  // re-arm hysteresis below the critical limit, degrees C
  localparam logic signed [8:0] FMC_CRIT_HYST_C = 9'sd5;
  localparam int FMC_CLK_HZ = 100_000_000;
  localparam int FMC_FAST_UPDATE_MS = 250;
  localparam int FMC_SLOW_UPDATE_MS = 1000;
  localparam int FMC_FAST_UPDATE_CYCLES = FMC_CLK_HZ / 1000 * FMC_FAST_UPDATE_MS;
  localparam int FMC_SLOW_UPDATE_CYCLES = FMC_CLK_HZ / 1000 * FMC_SLOW_UPDATE_MS;
  localparam int FMC_TACH_CNT_W = 27;
endpackage : fmc_pkg

// ===== design/fmc_regs.sv
/*
  Configuration register four and the upper half of status register one
  of a fan monitor, with status flags (all but sensor fail clear on read) and their pin effects.
  Assumes an SMBus slave engine presents byte accesses: a read strobe when
  the byte is fetched and a done strobe after it has gone out on the bus.
  Temperatures and limits are signed whole degrees, synchronous to clk.
*/
// Behaviour
// [R1] host must write one to bit 7
// [R2] bit 6 selects two or four pulses
// [R3] bit 5 selects 250ms or 1s update
// [R4] bit 4 enables over-temperature pin drive
// [R5] reserved bits read 1000, ignore writes
// [R6] config at 0x04 resets to 0x08
// [R7] flags latch until resolved and read
// [R8] read clears flags, reassert next monitor cycle
// [R9] local low flag at or below limit
// [R10] local high flag at or above limit
// [R11] sensor fault: flag, pin, force -128
// [R12] sensor fail flag alerts when enabled
// [R13] sensor fail flag cleared only by reset
// [R14] remote critical flag drives critical pin low
// [R15] remote critical flag alerts when enabled
// [R16] critical rearms only 5C below limit
// [R17] status at 0x02 resets to 0x00
// [R18] clear after read returns, keep new events
module fmc_regs
  import fmc_pkg::*;
#(
  parameter int FAST_CYCLES = FMC_FAST_UPDATE_CYCLES,
  parameter int SLOW_CYCLES = FMC_SLOW_UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic softReset,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic regRdDone,
  output logic [7:0] regRdData,
  input wire logic monitorTick,
  input wire logic signed [7:0] localTemp,
  input wire logic signed [7:0] localLowLimit,
  input wire logic signed [7:0] localHighLimit,
  input wire logic signed [7:0] remoteTemp,
  input wire logic signed [7:0] remoteCritLimit,
  input wire logic remoteSensorFault,
  input wire logic sensor_fail_irq_enable,
  input wire logic critical_irq_enable,
  output logic [7:0] remoteTempData,
  output logic pulses_per_rev_select,
  output logic tachUpdateStrobe,
  output logic overtemp_out_pin_o,
  output logic overtemp_out_pin_oe,
  output logic critical_temp_pin_o,
  output logic critical_temp_pin_oe,
  output logic smbAlert
);

  logic [7:4] cfg_q;
  logic local_low_flag_q;
  logic local_high_flag_q;
  logic remote_sensor_fail_flag_q;
  logic remote_critical_flag_q;
  logic critArmed_q;
  logic rdPending_q;
  logic [7:0] rdSnap_q;
  logic [FMC_TACH_CNT_W-1:0] tachCnt_q;
  logic [7:0] statusNow;
  logic [7:0] rdClear;
  logic localLowCond;
  logic localHighCond;
  logic critCond;
  logic critRearmCond;
  logic signed [8:0] critRearmLevel;
  logic [FMC_TACH_CNT_W-1:0] tachLast;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] status,
                                          input logic [7:4] cfg);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      FMC_STATUS_ONE_ADDR: val = status;
      FMC_CONFIG_FOUR_ADDR: val = {cfg, FMC_CONFIG_FIXED_BITS}; // R5
      default: val = 8'h00;
    endcase
    return val;
  endfunction : read_mux

  assign statusNow = {local_low_flag_q, local_high_flag_q, remote_sensor_fail_flag_q,
                      remote_critical_flag_q, 4'h0};
  assign localLowCond = localTemp <= localLowLimit; // R9
  assign localHighCond = localTemp >= localHighLimit; // R10
  assign critCond = remoteTemp > remoteCritLimit; // R14
  assign critRearmLevel = 9'(remoteCritLimit) - FMC_CRIT_HYST_C;
  assign critRearmCond = 9'(remoteTemp) <= critRearmLevel; // R16
  // only bits the host actually saw are cleared, so events during the read survive
  assign rdClear = (rdPending_q && regRdDone) ? rdSnap_q : 8'h00; // R18
  assign tachLast = cfg_q[FMC_CFG_FAST_BIT] ? FMC_TACH_CNT_W'(FAST_CYCLES - 1)
                                             : FMC_TACH_CNT_W'(SLOW_CYCLES - 1);

  // config register; mode bit stored as written, host is expected to set it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= FMC_CONFIG_FOUR_RESET[7:4]; // R6
    end else if (clkEn) begin
      if (softReset) begin
        cfg_q <= FMC_CONFIG_FOUR_RESET[7:4]; // R6
      end else if (regWrEn && regAddr == FMC_CONFIG_FOUR_ADDR) begin
        cfg_q <= regWrData[7:4]; // R1 R5
      end
    end
  end

  // read capture and snapshot for the later clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
      rdPending_q <= 1'b0;
      rdSnap_q <= 8'h00;
    end else if (clkEn) begin
      if (regRdEn) begin
        regRdData <= read_mux(regAddr, statusNow, cfg_q);
        rdPending_q <= regAddr == FMC_STATUS_ONE_ADDR;
        rdSnap_q <= statusNow;
      end else if (regRdDone || softReset) begin
        rdPending_q <= 1'b0;
      end
    end
  end

  // local limit flags: set on monitor cycle wins over the read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      local_low_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_LOCAL_LOW_BIT]; // R17
      local_high_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_LOCAL_HIGH_BIT]; // R17
    end else if (clkEn) begin
      if (softReset) begin
        local_low_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_LOCAL_LOW_BIT];
        local_high_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_LOCAL_HIGH_BIT];
      end else begin
        if (monitorTick && localLowCond) begin
          local_low_flag_q <= 1'b1; // R7 R8 R9
        end else if (rdClear[FMC_ST_LOCAL_LOW_BIT]) begin
          local_low_flag_q <= 1'b0; // R8
        end
        if (monitorTick && localHighCond) begin
          local_high_flag_q <= 1'b1; // R7 R8 R10
        end else if (rdClear[FMC_ST_LOCAL_HIGH_BIT]) begin
          local_high_flag_q <= 1'b0; // R8
        end
      end
    end
  end

  // sensor failure: sticky through reads, only resets clear it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_sensor_fail_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_SENSOR_FAIL_BIT];
    end else if (clkEn) begin
      if (softReset) begin
        remote_sensor_fail_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_SENSOR_FAIL_BIT]; // R13
      end else if (remoteSensorFault) begin
        remote_sensor_fail_flag_q <= 1'b1; // R11
      end
    end
  end

  // remote critical with read-clear lockout until 5C of hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_critical_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_REMOTE_CRIT_BIT];
      critArmed_q <= 1'b1;
    end else if (clkEn) begin
      if (softReset) begin
        remote_critical_flag_q <= FMC_STATUS_ONE_RESET[FMC_ST_REMOTE_CRIT_BIT];
        critArmed_q <= 1'b1;
      end else if (monitorTick && critCond && critArmed_q) begin
        remote_critical_flag_q <= 1'b1; // R14 R7
      end else if (rdClear[FMC_ST_REMOTE_CRIT_BIT]) begin
        remote_critical_flag_q <= 1'b0;
        critArmed_q <= 1'b0; // R16
      end else if (monitorTick && critRearmCond) begin
        critArmed_q <= 1'b1; // R16
      end
    end
  end

  // tach refresh timer; no restart on rate change, the >= compare ends an overlong count at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tachCnt_q <= '0;
      tachUpdateStrobe <= 1'b0;
    end else if (clkEn) begin
      if (softReset || tachCnt_q >= tachLast) begin
        tachCnt_q <= '0;
        tachUpdateStrobe <= !softReset; // R3
      end else begin
        tachCnt_q <= tachCnt_q + 1'b1;
        tachUpdateStrobe <= 1'b0;
      end
    end
  end

  // pins, alert and derived outputs, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulses_per_rev_select <= FMC_CONFIG_FOUR_RESET[FMC_CFG_PULSES_BIT];
      overtemp_out_pin_o <= 1'b1;
      overtemp_out_pin_oe <= 1'b0;
      critical_temp_pin_o <= 1'b0;
      critical_temp_pin_oe <= 1'b0;
      smbAlert <= 1'b0;
      remoteTempData <= 8'h00;
    end else if (clkEn) begin
      pulses_per_rev_select <= cfg_q[FMC_CFG_PULSES_BIT]; // R2
      // active low; high impedance unless enabled
      overtemp_out_pin_o <= !remote_sensor_fail_flag_q; // R11
      overtemp_out_pin_oe <= cfg_q[FMC_CFG_OUTEN_BIT]; // R4
      critical_temp_pin_o <= 1'b0;
      critical_temp_pin_oe <= remote_critical_flag_q; // R14
      smbAlert <= (remote_sensor_fail_flag_q && sensor_fail_irq_enable) // R12
                  || (remote_critical_flag_q && critical_irq_enable); // R15
      remoteTempData <= remote_sensor_fail_flag_q ? FMC_FAULT_TEMP : 8'(remoteTemp); // R11
    end
  end

endmodule : fmc_regs

// ===== test/fmc_host_model.sv
/* host-side model of the register byte port, as an SMBus engine drives it
   assumes the bench calls its tasks; signals change on falling clk edges */
module fmc_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  output logic regRdDone,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {regAddr, regWrEn, regWrData, regRdEn, regRdDone} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    // stale data inverted so a late sample cannot pass
    @(negedge clk) {regWrData, regWrEn} = {~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {regAddr, regRdEn} = {a, 1'b1};
    @(negedge clk) regRdEn = 1'b0;
    @(negedge clk) d = regRdData;
  endtask : rd
  task automatic done();
    @(negedge clk) regRdDone = 1'b1;
    @(negedge clk) regRdDone = 1'b0;
  endtask : done
endmodule : fmc_host_model

// ===== test/fmc_regs_assertions.sv
/* port assertions for fmc_regs
   bound into every instance; single clock, async active-low reset */
module fmc_regs_assertions
  import fmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic remoteSensorFault,
  input wire logic sensor_fail_irq_enable,
  input wire logic critical_irq_enable,
  input wire logic [7:0] remoteTempData,
  input wire logic overtemp_out_pin_o,
  input wire logic overtemp_out_pin_oe,
  input wire logic critical_temp_pin_o,
  input wire logic critical_temp_pin_oe,
  input wire logic smbAlert
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_cfg_low_nibble: assert property (
    regRdEn && regAddr == FMC_CONFIG_FOUR_ADDR |=> regRdData[3:0] == 4'h8) else $error("cfg nibble");
  a_outpin_oe_cfg: assert property (
    regWrEn && regAddr == FMC_CONFIG_FOUR_ADDR |-> ##2 overtemp_out_pin_oe == $past(regWrData[4], 2))
    else $error("overtemp enable");
  a_fault_temp: assert property (remoteSensorFault |-> ##2 remoteTempData == FMC_FAULT_TEMP)
    else $error("fault temp");
  a_fault_ovr: assert property (remoteSensorFault |-> ##2 !overtemp_out_pin_o)
    else $error("fault pin");
  a_fail_sticky: assert property (!overtemp_out_pin_o && !$past(softReset) |=> !overtemp_out_pin_o)
    else $error("fail cleared");
  a_fail_alert: assert property (
    (remoteSensorFault && sensor_fail_irq_enable) ##1 sensor_fail_irq_enable |=> smbAlert)
    else $error("fail alert");
  a_crit_pin_low: assert property (critical_temp_pin_oe |-> !critical_temp_pin_o)
    else $error("crit pin");
  a_crit_alert: assert property ($past(critical_irq_enable) && critical_temp_pin_oe |-> smbAlert)
    else $error("crit alert");
  c_crit: cover property (critical_temp_pin_oe);
  c_fail: cover property (!overtemp_out_pin_o && overtemp_out_pin_oe);
  c_status_rd: cover property (regRdEn && regAddr == FMC_STATUS_ONE_ADDR);
endmodule : fmc_regs_assertions
bind fmc_regs fmc_regs_assertions chk_u (.clk, .rst_n, .softReset, .regAddr, .regWrEn, .regWrData, .regRdEn,
  .regRdData, .remoteSensorFault, .sensor_fail_irq_enable, .critical_irq_enable, .remoteTempData,
  .overtemp_out_pin_o, .overtemp_out_pin_oe, .critical_temp_pin_o, .critical_temp_pin_oe, .smbAlert);

// ===== test/fmc_regs_test.sv
/* self-checking bench for fmc_regs driven through the host model
   tach periods shortened to 5 and 20 cycles; limits held constant */
module fmc_regs_test;
  import fmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, softReset = 1'b0, monitorTick = 1'b0;
  logic remoteSensorFault = 1'b0, sensor_fail_irq_enable = 1'b1, critical_irq_enable = 1'b1;
  logic signed [7:0] localTemp = 8'sh19, remoteTemp = 8'sh19;
  logic signed [7:0] localLowLimit = 8'shf6, localHighLimit = 8'sh40, remoteCritLimit = 8'sh50;
  logic [7:0] regAddr, regWrData, regRdData, remoteTempData, rd;
  logic regWrEn, regRdEn, regRdDone, pulses_per_rev_select, tachUpdateStrobe, overtemp_out_pin_o;
  logic overtemp_out_pin_oe, critical_temp_pin_o, critical_temp_pin_oe, smbAlert;
  int num_errors = 0;
  int checks_done = 0;
  fmc_regs #(.FAST_CYCLES(5), .SLOW_CYCLES(20)) dut_u (.*);
  fmc_host_model host_u (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rd);
    chk(rd, exp);
  endtask : rdc
  task automatic tick();
    @(negedge clk) monitorTick = 1'b1;
    @(negedge clk) monitorTick = 1'b0;
    @(negedge clk);
  endtask : tick
  task automatic tach_period(input logic [7:0] cfg, input int expN);
    int n;
    host_u.wr(FMC_CONFIG_FOUR_ADDR, cfg);
    for (n = 0; n < 50 && !tachUpdateStrobe; n++) @(negedge clk);
    for (n = 1; n < 50; n++) begin
      @(negedge clk);
      if (tachUpdateStrobe) break;
    end
    chk(8'(n), 8'(expN));
  endtask : tach_period
  task automatic t_config();
    rdc(FMC_CONFIG_FOUR_ADDR, 8'h08);
    rdc(FMC_STATUS_ONE_ADDR, 8'h00);
    host_u.wr(FMC_CONFIG_FOUR_ADDR, 8'hf7);
    rdc(FMC_CONFIG_FOUR_ADDR, 8'hf8);
    chk({6'h0, pulses_per_rev_select, overtemp_out_pin_oe}, 8'h03);
    host_u.wr(FMC_STATUS_ONE_ADDR, 8'hff);
    rdc(FMC_STATUS_ONE_ADDR, 8'h00);
    rdc(8'h10, 8'h00);
    tach_period(8'ha0, 5);
    tach_period(8'h80, 20);
  endtask : t_config
  task automatic t_local();
    localTemp = 8'shf6;
    tick();
    rdc(FMC_STATUS_ONE_ADDR, 8'h80);
    localTemp = 8'sh40;
    tick();
    rdc(FMC_STATUS_ONE_ADDR, 8'hc0);
    host_u.done();
    rdc(FMC_STATUS_ONE_ADDR, 8'h00);
    tick();
    rdc(FMC_STATUS_ONE_ADDR, 8'h40);
    host_u.done();
    localTemp = 8'sh19;
    tick();
    rdc(FMC_STATUS_ONE_ADDR, 8'h00);
    localTemp = 8'shf6;
    tick();
    host_u.done();
    rdc(FMC_STATUS_ONE_ADDR, 8'h80);
    host_u.done();
    localTemp = 8'sh19;
  endtask : t_local
  task automatic t_crit();
    remoteTemp = 8'sh51;
    tick();
    chk({5'h0, critical_temp_pin_oe, critical_temp_pin_o, smbAlert}, 8'h05);
    critical_irq_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h0, smbAlert}, 8'h00);
    critical_irq_enable = 1'b1;
    rdc(FMC_STATUS_ONE_ADDR, 8'h10);
    host_u.done();
    remoteTemp = 8'sh4c;
    tick();
    remoteTemp = 8'sh51;
    tick();
    rdc(FMC_STATUS_ONE_ADDR, 8'h00);
    remoteTemp = 8'sh4b;
    tick();
    remoteTemp = 8'sh51;
    tick();
    rdc(FMC_STATUS_ONE_ADDR, 8'h10);
    host_u.done();
  endtask : t_crit
  task automatic t_fault();
    host_u.wr(FMC_CONFIG_FOUR_ADDR, 8'h90);
    remoteSensorFault = 1'b1;
    @(negedge clk) remoteSensorFault = 1'b0;
    repeat (2) @(negedge clk);
    chk(remoteTempData, FMC_FAULT_TEMP);
    chk({5'h0, overtemp_out_pin_oe, overtemp_out_pin_o, smbAlert}, 8'h05);
    rdc(FMC_STATUS_ONE_ADDR, 8'h20);
    host_u.done();
    rdc(FMC_STATUS_ONE_ADDR, 8'h20);
    @(negedge clk) softReset = 1'b1;
    @(negedge clk) softReset = 1'b0;
    rdc(FMC_STATUS_ONE_ADDR, 8'h00);
    rdc(FMC_CONFIG_FOUR_ADDR, 8'h08);
    chk({5'h0, overtemp_out_pin_oe, overtemp_out_pin_o, smbAlert}, 8'h02);
  endtask : t_fault
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_config();
    t_local();
    t_crit();
    t_fault();
    complete_run();
  end
  initial begin
    #100us;
    num_errors++;
    complete_run();
  end
endmodule : fmc_regs_test
